// File: core/pfs_pkg.sv
// Constants shared by the fault status register bank
package pfs_pkg;

  // Command codes answered or acted on by this block
  localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
  localparam logic [7:0] CMD_OUT_CURR_STAT  = 8'h7b;
  localparam logic [7:0] CMD_IN_VOLT_STAT   = 8'h7c;
  localparam logic [7:0] CMD_TEMP_STAT      = 8'h7d;

  // Limit commands that set the comparator thresholds elsewhere
  localparam logic [7:0] CMD_VIN_OV_FLT_LIM = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_WRN_LIM = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_WRN_LIM = 8'h58;
  localparam logic [7:0] CMD_VIN_OFF_LIM    = 8'h36;
  localparam logic [7:0] CMD_OT_FLT_LIM     = 8'h4f;
  localparam logic [7:0] CMD_OT_WRN_LIM     = 8'h51;

  // Bit positions inside the output current status byte
  localparam int OCS_OC_FAULT_BIT   = 7;
  localparam int OCS_OC_WARN_BIT    = 5;
  localparam int OCS_OP_WARN_BIT    = 0;

  // Bit positions inside the input voltage status byte
  localparam int IVS_OV_FAULT_BIT   = 7;
  localparam int IVS_OV_WARN_BIT    = 6;
  localparam int IVS_UV_WARN_BIT    = 5;
  localparam int IVS_UV_FAULT_BIT   = 4;
  localparam int IVS_LOCKOUT_BIT    = 3;

  // Bit positions inside the temperature status byte
  localparam int TMS_OT_FAULT_BIT   = 7;
  localparam int TMS_OT_WARN_BIT    = 6;
  localparam int TMS_DIE_OT_BIT     = 0;

  // Slots of the sticky bit bank
  localparam int SLOT_OC_FAULT      = 0;
  localparam int SLOT_OC_WARN       = 1;
  localparam int SLOT_OP_WARN       = 2;
  localparam int SLOT_OV_FAULT      = 3;
  localparam int SLOT_OV_WARN       = 4;
  localparam int SLOT_UV_WARN       = 5;
  localparam int SLOT_UV_FAULT      = 6;
  localparam int SLOT_OT_FAULT      = 7;
  localparam int SLOT_OT_WARN       = 8;
  localparam int SLOT_DIE_OT        = 9;
  localparam int NUM_SLOTS          = 10;

  // Reset values
  localparam logic [NUM_SLOTS-1:0] SLOTS_RESET = 10'h000;
  localparam logic [7:0]           BYTE_RESET  = 8'h00;

endpackage

// File: core/pfs_latch_if.sv
// Interface joining the status logic to its sticky bit bank
`timescale 1ns/10ps
`default_nettype none

interface pfs_latch_if #(
  parameter int W = 10
);
  logic [W-1:0] cond;     // Condition levels, high while present
  logic [W-1:0] clear;    // Clear request per bit
  logic [W-1:0] latched;  // Sticky bit state

  // Side that feeds conditions and reads the bits
  modport owner (output cond, output clear, input latched);
  // Side that holds the bits
  modport bank  (input cond, input clear, output latched);
endinterface

`default_nettype wire

// File: core/pfs_latch_bank.sv
// Bank of sticky status bits, set by a condition and cleared on command
`timescale 1ns/10ps
`default_nettype none

module pfs_latch_bank
  import pfs_pkg::*;
#(
  parameter int W = pfs_pkg::NUM_SLOTS
) (
  input  wire logic  mclk_i,   // System clock
  input  wire logic  reset_i,  // Asynchronous reset, active high
  pfs_latch_if.bank  lat       // Conditions, clears and bit state
);

  logic [W-1:0] bit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // One flop per bit; a present condition outweighs a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
          bit_reg[g] <= 1'b0;
        end else if (lat.cond[g]) begin
          bit_reg[g] <= 1'b1;
        end else if (lat.clear[g]) begin
          bit_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Bits are visible straight from the flops
  assign lat.latched = bit_reg;

endmodule

`default_nettype wire

// File: core/pfs_status_regs.sv
// Output current, input voltage and temperature fault status registers
`timescale 1ns/10ps
`default_nettype none

module pfs_status_regs
  import pfs_pkg::*;
(
  input  wire logic       mclk_i,                          // Clock
  input  wire logic       reset_i,                         // Async reset
  // Comparator results, high while the condition holds
  input  wire logic       oc_fault_trip_i,                 // Total OCP
  input  wire logic       oc_warn_trip_i,                  // Total OC warn
  input  wire logic       output_overpower_warning_flag_i, // OP warning
  input  wire logic       vin_ov_fault_trip_i,             // Above OV fault
  input  wire logic       vin_ov_warn_trip_i,              // Above OV warn
  input  wire logic       vin_uv_warn_trip_i,              // Below UV warn
  input  wire logic       vin_below_off_i,                 // Below turn-off
  input  wire logic       ot_fault_trip_i,                 // Above OT fault
  input  wire logic       ot_warn_trip_i,                  // Above OT warn
  input  wire logic       die_overheat_flag_i,             // Die overheat
  // Decoded command from the serial front end
  input  wire logic       cmd_valid_i,                     // Command strobe
  input  wire logic       cmd_read_i,                      // 1 read, 0 write
  input  wire logic [7:0] cmd_code_i,                      // Command code
  input  wire logic [7:0] cmd_data_i,                      // Write data
  // Answer to the front end
  output logic            rsp_valid_o,                     // Answer strobe
  output logic            rsp_known_o,                     // Code handled
  output logic [7:0]      rsp_data_o,                      // Read byte
  output logic            input_lockout_live_flag_o        // Live lockout
);

  import pfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // True for the three status read codes handled here
  function automatic logic is_status_code(input logic [7:0] code);
    is_status_code = (code == CMD_OUT_CURR_STAT) ||
                     (code == CMD_IN_VOLT_STAT)  ||
                     (code == CMD_TEMP_STAT);
  endfunction

  // Assemble the byte returned for a status code
  function automatic logic [7:0] status_byte(
    input logic [7:0]           code,
    input logic [NUM_SLOTS-1:0] s,
    input logic                 live
  );
    logic [7:0] b;
    b = BYTE_RESET;
    if (code == CMD_OUT_CURR_STAT) begin
      b[OCS_OC_FAULT_BIT] = s[SLOT_OC_FAULT];
      b[OCS_OC_WARN_BIT]  = s[SLOT_OC_WARN];
      b[OCS_OP_WARN_BIT]  = s[SLOT_OP_WARN];
    end else if (code == CMD_IN_VOLT_STAT) begin
      b[IVS_OV_FAULT_BIT] = s[SLOT_OV_FAULT];
      b[IVS_OV_WARN_BIT]  = s[SLOT_OV_WARN];
      b[IVS_UV_WARN_BIT]  = s[SLOT_UV_WARN];
      b[IVS_UV_FAULT_BIT] = s[SLOT_UV_FAULT];
      b[IVS_LOCKOUT_BIT]  = live;
    end else if (code == CMD_TEMP_STAT) begin
      b[TMS_OT_FAULT_BIT] = s[SLOT_OT_FAULT];
      b[TMS_OT_WARN_BIT]  = s[SLOT_OT_WARN];
      b[TMS_DIE_OT_BIT]   = s[SLOT_DIE_OT];
    end
    status_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sticky bit bank

  pfs_latch_if #(.W(NUM_SLOTS)) lat_if ();

  pfs_latch_bank #(
    .W       (NUM_SLOTS)
  ) u_bank (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .lat     (lat_if.bank)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Condition wiring into the bank
  always_comb begin
    lat_if.cond                = '0;
    lat_if.cond[SLOT_OC_FAULT] = oc_fault_trip_i;
    lat_if.cond[SLOT_OC_WARN]  = oc_warn_trip_i;
    lat_if.cond[SLOT_OP_WARN]  = output_overpower_warning_flag_i;
    lat_if.cond[SLOT_OV_FAULT] = vin_ov_fault_trip_i;
    lat_if.cond[SLOT_OV_WARN]  = vin_ov_warn_trip_i;
    lat_if.cond[SLOT_UV_WARN]  = vin_uv_warn_trip_i;
    lat_if.cond[SLOT_UV_FAULT] = vin_below_off_i;
    lat_if.cond[SLOT_OT_FAULT] = ot_fault_trip_i;
    lat_if.cond[SLOT_OT_WARN]  = ot_warn_trip_i;
    lat_if.cond[SLOT_DIE_OT]   = die_overheat_flag_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  logic clear_cmd;
  logic status_rd;
  logic status_wr;
  logic known_cmd;

  // Only a write of the clear code clears; reads never touch the bank
  assign clear_cmd = cmd_valid_i && !cmd_read_i &&
                     (cmd_code_i == CMD_CLEAR_FAULTS);
  assign status_rd = cmd_valid_i && cmd_read_i &&
                     is_status_code(cmd_code_i);
  // Writes to the read-only bytes are accepted and dropped
  assign status_wr = cmd_valid_i && !cmd_read_i &&
                     is_status_code(cmd_code_i);
  assign known_cmd = clear_cmd || status_rd || status_wr;

  // Clear fans out to every sticky bit at once
  assign lat_if.clear = {NUM_SLOTS{clear_cmd}};

  ////////////////////////////////////////////////////////////////////////////
  // Answer strobe and known flag, one cycle after the command
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_valid_o <= 1'b0;
      rsp_known_o <= 1'b0;
    end else begin
      rsp_valid_o <= cmd_valid_i;
      rsp_known_o <= known_cmd;
    end
  end

  // Read byte, sampled at the edge that takes the read; zero on any other command, held while idle
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rsp_data_o <= BYTE_RESET;
    end else if (status_rd) begin
      rsp_data_o <= status_byte(cmd_code_i, lat_if.latched,
                                vin_below_off_i);
    end else if (cmd_valid_i) begin
      rsp_data_o <= BYTE_RESET;
    end
  end

  // Live lockout mirror, no latching
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      input_lockout_live_flag_o <= 1'b0;
    end else begin
      input_lockout_live_flag_o <= vin_below_off_i;
    end
  end

  // Write data is not stored by any status byte
  logic unused_wdata;
  assign unused_wdata = ^cmd_data_i;

endmodule

`default_nettype wire

// File: dv/pfs_status_regs_asserts.sv
// Checker for the fault status register bank
`timescale 1ns/10ps
`default_nettype none
module pfs_status_regs_asserts
  import pfs_pkg::*;
(
  input wire logic       mclk_i,                   // Clock
  input wire logic       reset_i,                  // Reset
  input wire logic       oc_fault_trip_i,          // OCP trip
  input wire logic       vin_below_off_i,          // Below turn-off
  input wire logic       cmd_valid_i,              // Strobe
  input wire logic       cmd_read_i,               // Read select
  input wire logic [7:0] cmd_code_i,               // Code
  input wire logic       rsp_valid_o,              // Answer
  input wire logic       rsp_known_o,              // Handled
  input wire logic [7:0] rsp_data_o,               // Byte
  input wire logic       input_lockout_live_flag_o // Live lockout
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // Decoded command kinds
  wire rd  = cmd_valid_i && cmd_read_i;
  wire sts = cmd_code_i inside {CMD_OUT_CURR_STAT, CMD_IN_VOLT_STAT,
                                CMD_TEMP_STAT};
  wire clr = !cmd_read_i && cmd_code_i == CMD_CLEAR_FAULTS;
  chk_answer_next: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("answer strobe missing");
  chk_no_spurious: assert property (!cmd_valid_i |=>
    !rsp_valid_o && $stable(rsp_data_o)) else $error("answer unprompted");
  chk_oc_reserved: assert property (rd &&
    cmd_code_i == CMD_OUT_CURR_STAT |=> rsp_known_o &&
    rsp_data_o[6] == 1'h0 && rsp_data_o[4:1] == 4'h0)
    else $error("output current reserved bits set");
  chk_in_layout: assert property (rd &&
    cmd_code_i == CMD_IN_VOLT_STAT |=> rsp_data_o[2:0] == 3'h0 &&
    rsp_data_o[3] == $past(vin_below_off_i))
    else $error("input byte layout wrong");
  chk_temp_reserved: assert property (rd &&
    cmd_code_i == CMD_TEMP_STAT |=> rsp_known_o &&
    rsp_data_o[5:1] == 5'h00) else $error("temp bits");
  chk_write_ignored: assert property (cmd_valid_i &&
    !cmd_read_i && sts |=> rsp_known_o && rsp_data_o == 8'h00)
    else $error("write answered");
  chk_unknown_code: assert property (cmd_valid_i && !sts && !clr
    |=> !rsp_known_o && rsp_data_o == 8'h00) else $error("unknown code");
  chk_oc_sticky: assert property (oc_fault_trip_i ##1
    (rd && cmd_code_i == CMD_OUT_CURR_STAT) |=> rsp_data_o[7])
    else $error("over-current bit not latched");
  chk_lockout_live: assert property (!reset_i |=>
    input_lockout_live_flag_o == $past(vin_below_off_i))
    else $error("lockout flag not live");
  // Main scenarios reached
  cov_clear: cover property (cmd_valid_i && clr);
  cov_live: cover property (rd && cmd_code_i == CMD_IN_VOLT_STAT
    && vin_below_off_i);
  cov_refused: cover property (rsp_valid_o && !rsp_known_o);
endmodule
bind pfs_status_regs pfs_status_regs_asserts u_chk (.mclk_i, .reset_i,
  .oc_fault_trip_i, .vin_below_off_i, .cmd_valid_i, .cmd_read_i,
  .cmd_code_i, .rsp_valid_o, .rsp_known_o, .rsp_data_o,
  .input_lockout_live_flag_o);
`default_nettype wire

// File: dv/pfs_host_model.sv
// Command host that issues status reads, writes and clears
`timescale 1ns/10ps
`default_nettype none
module pfs_host_model (
  input  wire logic       mclk_i,      // Clock
  output var  logic       cmd_valid_o, // Command strobe
  output var  logic       cmd_read_o,  // Read select
  output var  logic [7:0] cmd_code_o,  // Command code
  output var  logic [7:0] cmd_data_o,  // Write data
  input  wire logic       rsp_valid_i, // Answer strobe
  input  wire logic       rsp_known_i, // Code handled
  input  wire logic [7:0] rsp_data_i   // Answer byte
);
  // Idle request lines at time zero
  initial begin
    cmd_valid_o = 1'h0;
    cmd_read_o = 1'h0;
    cmd_code_o = 8'h00;
    cmd_data_o = 8'h00;
  end
  // One byte transfer; the answer is taken one edge after the command
  task automatic xfer(input logic rd, input logic [7:0] code,
                      output logic [9:0] ans);
    @(posedge mclk_i);
    cmd_valid_o <= 1'h1;
    cmd_read_o <= rd;
    cmd_code_o <= code;
    cmd_data_o <= 8'hff;
    @(posedge mclk_i);
    cmd_valid_o <= 1'h0;
    cmd_read_o <= ~rd;
    cmd_code_o <= ~code;
    cmd_data_o <= 8'h00;
    @(posedge mclk_i);
    ans = {rsp_valid_i, rsp_known_i, rsp_data_i};
  endtask
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the fault status register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pfs_pkg::*;
  localparam logic [7:0] CODES [3] = '{CMD_OUT_CURR_STAT, CMD_IN_VOLT_STAT,
                                       CMD_TEMP_STAT};
  logic       mclk_i = 1'h0;
  logic       reset_i;
  logic [9:0] cond;
  logic [9:0] stk = 10'h000;
  logic       cv, cr, rv, rk;
  logic       lv;
  logic [7:0] cc, cd, rdat;
  int         fail_count = 0;
  int         tests_run = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock at 200 MHz
  always #2.5 mclk_i = ~mclk_i;
  pfs_status_regs u_dut (.mclk_i, .reset_i, .oc_fault_trip_i(cond[0]),
    .oc_warn_trip_i(cond[1]), .output_overpower_warning_flag_i(cond[2]),
    .vin_ov_fault_trip_i(cond[3]), .vin_ov_warn_trip_i(cond[4]),
    .vin_uv_warn_trip_i(cond[5]), .vin_below_off_i(cond[6]),
    .ot_fault_trip_i(cond[7]), .ot_warn_trip_i(cond[8]),
    .die_overheat_flag_i(cond[9]), .cmd_valid_i(cv), .cmd_read_i(cr),
    .cmd_code_i(cc), .cmd_data_i(cd), .rsp_valid_o(rv), .rsp_known_o(rk),
    .rsp_data_o(rdat), .input_lockout_live_flag_o(lv));
  pfs_host_model u_host (.mclk_i, .cmd_valid_o(cv), .cmd_read_o(cr),
    .cmd_code_o(cc), .cmd_data_o(cd), .rsp_valid_i(rv), .rsp_known_i(rk),
    .rsp_data_i(rdat));
  ////////////////////////////////////////////////////////////////////////
  // Expected status byte from the sticky and live conditions
  function automatic logic [7:0] expb(input int c);
    case (c)
      0: return {stk[0], 1'h0, stk[1], 4'h0, stk[2]};
      1: return {stk[3], stk[4], stk[5], stk[6], cond[6], 3'h0};
      default: return {stk[7], stk[8], 5'h00, stk[9]};
    endcase
  endfunction
  // One transfer compared with its expected answer
  task automatic chk(input logic rd, input logic [7:0] code,
                     input logic [9:0] exp);
    logic [9:0] got;
    u_host.xfer(rd, code, got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED code %h exp %h got %h", code, exp, got);
    end
  endtask
  // Read all three status bytes
  task automatic rd_all();
    for (int c = 0; c < 3; c++)
      chk(1'h1, CODES[c], {2'h3, expb(c)});
  endtask
  // Live lockout output against its expected level
  task automatic chk_live(input logic exp);
    tests_run++;
    if (lv !== exp) begin
      fail_count++;
      $display("CHECK FAILED live lockout exp %h got %h", exp, lv);
    end
  endtask
  // Apply condition levels and note what must latch
  task automatic setc(input logic [9:0] v);
    @(posedge mclk_i);
    cond <= v;
    @(posedge mclk_i);
    stk = stk | v;
  endtask
  // Verdict and end of run
  task automatic conclude();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_i = 1'h1;
    cond = 10'h000;
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      setc(10'h001 << i);
      setc(10'h000);
      rd_all();
    end
    for (int c = 0; c < 3; c++)
      chk(1'h0, CODES[c], 10'h300);
    chk(1'h1, CMD_CLEAR_FAULTS, 10'h200);
    chk(1'h1, 8'h7e, 10'h200);
    rd_all();
    chk(1'h0, CMD_CLEAR_FAULTS, 10'h300);
    stk = 10'h000;
    rd_all();
    // Over-current and below-off held through a clear: set must win
    setc(10'h041);
    chk(1'h0, CMD_CLEAR_FAULTS, 10'h300);
    rd_all();
    chk_live(1'h1);
    setc(10'h000);
    rd_all();
    chk_live(1'h0);
    conclude();
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk_i);
    fail_count++;
    conclude();
  end
endmodule
`default_nettype wire
